// ===== verilog/pmr_pkg.sv
// Constants for the power mode and reset controller.
// Assumes a 25 MHz hclk and an AHB-Lite register slave.
//
// Notes on behaviour
// - Stand-by when mux field is 111, no channel pin high and limp home is off.
// - Error latches are cleared while in stand-by.
// - Entering stand-by sets the stand-by status bit.
// - A non-default mux value wakes the device after the wake time.
// - Falling into stand-by through the mux keeps register contents.
// - Pin wake delays turn-on by channel wake time unless a channel is on.
// - All pins low without logic supply returns to stand-by, clearing errors.
// - Limp home starts after the pin stays high beyond the acceptance time.
// - In limp home pins drive channels 1-3; a rising pin clears its error.
// - Any reset returns registers to defaults and clears all error flags.
// - Reset turns off register-driven outputs; pin-driven outputs stay.
// - During reset only channels 1-3 follow pins; mapping mode is off.
// - First transfer after any reset shows the transfer error flag.
// - Power-on reset ends with the logic supply; master waits wake time.
// - Writing the reset command bit resets like power-on; master waits.
// - In limp home reads work but every write is ignored.
// - In limp home writable registers are held at reset with battery present.
// - In limp home current sense is disabled.
// - Over-temperature latches work again right after any reset trigger.
// - The register bus works whenever logic supply is good, battery or not.

package pmr_pkg;

    // ********************************
    // Register map and fields
    // ********************************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam int CTRL_MUX_LSB = 0;
    localparam int CTRL_MAP_BIT = 3;
    localparam int CTRL_RST_BIT = 4;
    localparam int CTRL_OUT_LSB = 8;
    localparam int CTRL_MASK_LSB = 16;
    localparam int STAT_STB_BIT = 0;
    localparam int STAT_LIMP_BIT = 1;
    localparam int STAT_TER_BIT = 2;
    localparam int STAT_RDY_BIT = 3;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_ERR_LSB = 8;
    localparam int STAT_PWR_LSB = 16;
    localparam logic [2:0] MUX_STBY = 3'h7;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_NS = 40;
    localparam int WAKE_PO_NS = 100000;
    localparam int WAKE_CH_NS = 40000;
    localparam int LH_ACC_NS = 50000;
    localparam int XFER_TD_NS = 2000;
    localparam logic [11:0] WAKE_PO_CYC = 12'((WAKE_PO_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] WAKE_CH_CYC = 12'((WAKE_CH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] LH_ACC_CYC = 12'((LH_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] XFER_TD_CYC = 12'((XFER_TD_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {MODE_OFF, MODE_STANDBY, MODE_IDLE, MODE_NORMAL, MODE_LIMP} pmr_mode_t;

endpackage : pmr_pkg

// ===== verilog/pmr_ctrl.sv
// Power mode and reset controller with its AHB-Lite register slave.
// Assumes supply-good and pin inputs are asynchronous; error events
// come from power-stage logic on hclk.

`timescale 1ns/1ns

module pmr_ctrl #(
    parameter int NUM_CH = 6,
    parameter int NUM_PIN = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic logic_supply_ok,
    input wire logic battery_ok,
    input wire logic limp_home_input,
    input wire logic [NUM_PIN-1:0] channel_input_pin,
    input wire logic [NUM_CH-1:0] error_event,
    output logic [NUM_CH-1:0] power_outputs,
    output logic [2:0] sense_mux_select,
    output logic sense_enable,
    output logic standby_status_bit,
    output logic limp_active,
    output logic [2:0] power_mode
);

    // ********************************
    // Parameter checks
    // ********************************
    initial begin
        if (NUM_PIN < 1 || NUM_PIN > NUM_CH || NUM_CH > 16) begin
            $error("pmr_ctrl: unsupported channel or pin count");
        end
    end

    localparam int SW = NUM_PIN + 3;
    localparam int LH_I = NUM_PIN;
    localparam int VDD_I = NUM_PIN + 1;
    localparam int VBB_I = NUM_PIN + 2;

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic [SW-1:0] s3;
        logic [SW-1:0] flt;
        logic [11:0] lh_cnt;
        logic limp_q;
        logic [11:0] wake_cnt;
        logic ready_q;
        logic [11:0] stch_cnt;
        logic pins_ok_q;
        logic [11:0] soft_cnt;
        logic rst_prev_q;
        logic [2:0] mux_q;
        logic map_q;
        logic [NUM_CH-1:0] out_on_q;
        logic [NUM_CH-1:0] mask_q;
        logic [NUM_CH-1:0] err_q;
        logic [NUM_PIN-1:0] pin_prev_q;
        logic ter_q;
        logic stb_q;
        logic stby_prev_q;
        logic wr_q;
        logic [7:0] waddr_q;
        logic [31:0] rdata_q;
        logic [NUM_CH-1:0] pwr_q;
    } pmr_state_t;

    localparam pmr_state_t ST_RST = '{mux_q: pmr_pkg::MUX_STBY, ter_q: 1'b1, default: '0};

    pmr_state_t s;
    pmr_state_t n;

    logic [NUM_PIN-1:0] pins;
    logic pin_any;
    logic limp_pin;
    logic vdd_f;
    logic vbb_f;
    logic reg_rst;
    logic rst_trig;
    logic standby;
    logic acc;
    logic wr_ok;
    logic [NUM_CH-1:0] pin_drive;
    logic [NUM_CH-1:0] reg_drive;
    pmr_pkg::pmr_mode_t mode;

    // Address match on the low byte; upper bits must be zero.
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction : hit

    // Routes pins to channels; mapping only in plain operation.
    function automatic logic [NUM_CH-1:0] map_pins(input logic [NUM_PIN-1:0] p,
                                                    input logic en,
                                                    input logic [NUM_CH-1:0] m);
        logic [NUM_CH-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (en) begin
                r[i] = p[0] & m[i];
            end else if (i < NUM_PIN && i < 3) begin
                r[i] = p[i];
            end
        end
        map_pins = r;
    endfunction : map_pins

    // ********************************
    // Next-state logic
    // ********************************
    always_comb begin
        n = s;

        // Three-stage synchronisers; a level counts once stages two and three agree.
        n.s1 = {battery_ok, logic_supply_ok, limp_home_input, channel_input_pin};
        n.s2 = s.s1;
        n.s3 = s.s2;
        n.flt = (s.s3 & ~(s.s2 ^ s.s3)) | (s.flt & (s.s2 ^ s.s3));

        pins = s.flt[NUM_PIN-1:0];
        pin_any = |pins;
        limp_pin = s.flt[LH_I];
        vdd_f = s.flt[VDD_I];
        vbb_f = s.flt[VBB_I];

        // Limp home acceptance; any early drop restarts the count.
        if (!limp_pin) begin
            n.lh_cnt = '0;
            n.limp_q = 1'b0;
        end else if (s.lh_cnt == pmr_pkg::LH_ACC_CYC) begin
            n.limp_q = 1'b1;
        end else begin
            n.lh_cnt = s.lh_cnt + 12'h001;
        end

        // Register reset sources: logic supply, command hold, limp with battery.
        reg_rst = !vdd_f || (s.soft_cnt != '0) || (s.limp_q && vbb_f);
        rst_trig = reg_rst && !s.rst_prev_q;
        n.rst_prev_q = reg_rst;

        standby = (s.mux_q == pmr_pkg::MUX_STBY) && !pin_any && !s.limp_q;

        // Reported mode; worked out here so that a status read sees this cycle's mode.
        if (!vbb_f) begin
            mode = pmr_pkg::MODE_OFF;
        end else if (s.limp_q) begin
            mode = pmr_pkg::MODE_LIMP;
        end else if (standby) begin
            mode = pmr_pkg::MODE_STANDBY;
        end else if (s.pwr_q != '0) begin
            mode = pmr_pkg::MODE_NORMAL;
        end else begin
            mode = pmr_pkg::MODE_IDLE;
        end

        // Wake timer runs whenever the device is out of stand-by.
        if (standby) begin
            n.wake_cnt = pmr_pkg::WAKE_PO_CYC;
            n.ready_q = 1'b0;
        end else if (s.wake_cnt != '0) begin
            n.wake_cnt = s.wake_cnt - 12'h001;
        end else begin
            n.ready_q = 1'b1;
        end

        // Pin wake delay, skipped if another channel already conducts.
        if (!pin_any) begin
            n.stch_cnt = pmr_pkg::WAKE_CH_CYC;
            n.pins_ok_q = 1'b0;
        end else if (s.pwr_q != '0 || s.stch_cnt == '0) begin
            n.pins_ok_q = 1'b1;
        end else begin
            n.stch_cnt = s.stch_cnt - 12'h001;
        end

        // ********************************
        // AHB-Lite slave
        // ********************************
        // Zero wait state; bus stays alive on logic supply alone.
        acc = hsel && htrans[1] && hready;
        wr_ok = s.wr_q && vdd_f && !s.limp_q;
        n.wr_q = acc && hwrite;
        if (acc) begin
            n.waddr_q = haddr[7:0];
        end
        if (acc && !hwrite) begin
            n.rdata_q = '0;
            if (hit(haddr, pmr_pkg::CTRL_OFF)) begin
                n.rdata_q[pmr_pkg::CTRL_MUX_LSB +: 3] = s.mux_q;
                n.rdata_q[pmr_pkg::CTRL_MAP_BIT] = s.map_q;
                n.rdata_q[pmr_pkg::CTRL_OUT_LSB +: NUM_CH] = s.out_on_q;
                n.rdata_q[pmr_pkg::CTRL_MASK_LSB +: NUM_CH] = s.mask_q;
            end else if (hit(haddr, pmr_pkg::STAT_OFF)) begin
                n.rdata_q[pmr_pkg::STAT_STB_BIT] = s.stb_q;
                n.rdata_q[pmr_pkg::STAT_LIMP_BIT] = s.limp_q;
                n.rdata_q[pmr_pkg::STAT_TER_BIT] = s.ter_q;
                n.rdata_q[pmr_pkg::STAT_RDY_BIT] = s.ready_q;
                n.rdata_q[pmr_pkg::STAT_MODE_LSB +: 3] = mode;
                n.rdata_q[pmr_pkg::STAT_ERR_LSB +: NUM_CH] = s.err_q;
                n.rdata_q[pmr_pkg::STAT_PWR_LSB +: NUM_CH] = s.pwr_q;
            end
        end

        // Control write; the reset command bit is self-clearing.
        if (wr_ok && s.waddr_q == pmr_pkg::CTRL_OFF) begin
            n.mux_q = hwdata[pmr_pkg::CTRL_MUX_LSB +: 3];
            n.map_q = hwdata[pmr_pkg::CTRL_MAP_BIT];
            n.out_on_q = hwdata[pmr_pkg::CTRL_OUT_LSB +: NUM_CH];
            n.mask_q = hwdata[pmr_pkg::CTRL_MASK_LSB +: NUM_CH];
            if (hwdata[pmr_pkg::CTRL_RST_BIT]) begin
                n.soft_cnt = pmr_pkg::XFER_TD_CYC;
            end
        end
        if (s.soft_cnt != '0) begin
            n.soft_cnt = s.soft_cnt - 12'h001;
        end

        // Reset holds the writable registers at their defaults.
        if (reg_rst) begin
            n.mux_q = pmr_pkg::MUX_STBY;
            n.map_q = 1'b0;
            n.out_on_q = '0;
            n.mask_q = '0;
        end

        // Transfer error flag: set by a reset trigger, cleared by the next transfer.
        if (rst_trig) begin
            n.ter_q = 1'b1;
        end else if (acc) begin
            n.ter_q = 1'b0;
        end

        // Stand-by status: set on entry, cleared by a status read; set wins.
        n.stby_prev_q = standby;
        if (standby && !s.stby_prev_q) begin
            n.stb_q = 1'b1;
        end else if (acc && !hwrite && hit(haddr, pmr_pkg::STAT_OFF)) begin
            n.stb_q = 1'b0;
        end

        // Error latches; stand-by and reset clear, events beat pin-edge clears.
        n.pin_prev_q = pins;
        if (standby || rst_trig) begin
            n.err_q = '0;
        end else begin
            n.err_q = s.err_q | error_event;
            if (s.limp_q) begin
                n.err_q[NUM_PIN-1:0] = (s.err_q[NUM_PIN-1:0] & ~(pins & ~s.pin_prev_q))
                                       | error_event[NUM_PIN-1:0];
            end
        end

        // ********************************
        // Output drive
        // ********************************
        // Pins drive outputs with or without logic supply; mapping off in reset.
        pin_drive = map_pins(pins, s.map_q && !reg_rst && !s.limp_q, s.mask_q)
                    & {NUM_CH{s.pins_ok_q}};
        reg_drive = s.out_on_q & {NUM_CH{s.ready_q && !reg_rst && !s.limp_q}};
        n.pwr_q = (pin_drive | reg_drive) & ~s.err_q & {NUM_CH{vbb_f}};
    end

    // Single state register; asynchronous reset loads constants only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs come straight from state.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata_q;
    assign power_outputs = s.pwr_q;
    assign sense_mux_select = s.mux_q;
    assign sense_enable = s.ready_q && !s.limp_q && (s.mux_q != pmr_pkg::MUX_STBY);
    assign standby_status_bit = s.stb_q;
    assign limp_active = s.limp_q;
    assign power_mode = mode;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    localparam logic [11:0] LH_C = pmr_pkg::LH_ACC_CYC;

    sequence soft_wr;
        wr_ok && s.waddr_q == pmr_pkg::CTRL_OFF && hwdata[pmr_pkg::CTRL_RST_BIT];
    endsequence

    sequence pin_wake;
        $rose(pin_any) && s.pwr_q == '0 && s.stch_cnt == pmr_pkg::WAKE_CH_CYC;
    endsequence

    a_standby_status: assert property ($rose(standby) |=> s.stb_q)
        else $error("stand-by status not set");
    a_standby_clear: assert property (standby |=> s.err_q == '0)
        else $error("error latches kept in stand-by");
    a_limp_accept: assert property ($rose(s.limp_q) |-> $past(s.lh_cnt) == LH_C && $past(limp_pin))
        else $error("limp home accepted early");
    a_limp_nowrite: assert property (s.limp_q && s.wr_q && !reg_rst |=> $stable(s.mux_q))
        else $error("write taken in limp home");
    a_reset_outs: assert property (reg_rst |=> s.out_on_q == '0 && s.mux_q == pmr_pkg::MUX_STBY)
        else $error("registers not at default in reset");
    a_ter_first: assert property (rst_trig |=> s.ter_q)
        else $error("transfer error flag not set");
    a_soft_reset: assert property (soft_wr |=> ##1 reg_rst [*2])
        else $error("reset command not held");
    a_stch_delay: assert property (pin_wake |-> !s.pins_ok_q ##1 !s.pins_ok_q)
        else $error("pin wake delay skipped");
    a_limp_sense: assert property (s.limp_q |-> !sense_enable)
        else $error("current sense on in limp home");
    a_reset_pins: assert property (reg_rst |-> (pin_drive >> 3) == '0)
        else $error("pin drove a high channel in reset");

    // ********************************
    // Assertions on the remaining rules
    // ********************************
    // A transfer taken outside a reset trigger is the one that shows the flag.
    sequence bus_take;
        acc && !rst_trig;
    endsequence

    // Register-driven channels wait for the wake timer.
    a_wake_hold: assert property (s.wake_cnt != '0 |-> reg_drive == '0)
        else $error("register output on before wake time");
    // Stand-by without a write leaves the programmed outputs and mask alone.
    a_standby_keep: assert property (standby && !reg_rst && !wr_ok
        |=> $stable(s.out_on_q) && $stable(s.mask_q))
        else $error("stand-by changed the register settings");
    // A pin that rises while a channel conducts is passed at once.
    a_pin_skip: assert property ($rose(pin_any) && s.pwr_q != '0 |=> s.pins_ok_q)
        else $error("pin wake delayed with a channel on");
    // Every reset trigger clears the error latches.
    a_reset_errclr: assert property (rst_trig |=> s.err_q == '0)
        else $error("error latch survived a reset trigger");
    // Reset never lets the output-on bits through.
    a_reset_regout: assert property (reg_rst |-> reg_drive == '0)
        else $error("register output on during reset");
    // Once the flag has been shown, the taken transfer clears it.
    a_ter_clear: assert property (bus_take |=> !s.ter_q)
        else $error("transfer error flag not cleared");
    // Limp home with battery holds the writable registers at reset.
    a_limp_held: assert property (s.limp_q && vbb_f |=> s.mux_q == pmr_pkg::MUX_STBY && s.out_on_q == '0)
        else $error("registers not held in limp home");
    // New error events are latched outside the clearing conditions.
    a_err_latch: assert property (!standby && !rst_trig
        |=> (s.err_q & $past(error_event)) == $past(error_event))
        else $error("error event not latched");
    // An early drop of the limp pin restarts the acceptance count.
    a_limp_drop: assert property (!limp_pin |=> s.lh_cnt == '0 && !s.limp_q)
        else $error("limp count kept after pin drop");

endmodule : pmr_ctrl

// ===== verif/pmr_host_model.sv
// AHB-Lite master model that stands in for the controlling microcontroller.
// Assumes a single slave whose hreadyout is fed back as hready.
`timescale 1ns/1ns

module pmr_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // The bus idles at time zero so that nothing is taken before the first call.
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One single word transfer; callers keep the wake and reset delays first.
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk iff hready === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge hclk iff hready === 1'b1);
        rdata = hrdata;
        // A released data bus shows the inverse so stale data is never mistaken for fresh.
        hwdata <= ~wdata;
    endtask : xfer
endmodule : pmr_host_model

// ===== verif/testbench.sv
// Self-checking bench for the power mode and reset controller.
// Assumes the register map and wake counts of the controller package.
`timescale 1ns/1ns

module testbench;
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, sense_mux_select, power_mode, channel_input_pin;
    logic logic_supply_ok, battery_ok, limp_home_input, sense_enable, standby_status_bit, limp_active;
    logic [5:0] error_event, power_outputs;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [31:0] STB = 32'(pmr_pkg::MODE_STANDBY);

    // ********************************
    // Clock, instances and timeout
    // ********************************
    always #20 hclk = ~hclk;

    pmr_ctrl #(.NUM_CH(6), .NUM_PIN(3)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .logic_supply_ok(logic_supply_ok),
        .battery_ok(battery_ok), .limp_home_input(limp_home_input), .channel_input_pin(channel_input_pin),
        .error_event(error_event), .power_outputs(power_outputs), .sense_mux_select(sense_mux_select),
        .sense_enable(sense_enable), .standby_status_bit(standby_status_bit), .limp_active(limp_active),
        .power_mode(power_mode));

    pmr_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // A hang is cut short well beyond the roughly 17000 cycles the sequence needs.
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, {24'h0, a}, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] r;
        host.xfer(1'b0, {24'h0, a}, 32'h0, r);
        chk(r & mask, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    // Pulses the error inputs for one clock.
    task automatic ev(input logic [5:0] m);
        @(posedge hclk);
        error_event <= m;
        @(posedge hclk);
        error_event <= 6'h00;
    endtask : ev

    task automatic pins(input logic [2:0] p, input int n);
        @(posedge hclk);
        channel_input_pin <= p;
        cyc(n);
    endtask : pins

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        hresetn = 1'b0;
        logic_supply_ok = 1'b1;
        battery_ok = 1'b1;
        limp_home_input = 1'b0;
        channel_input_pin = 3'h0;
        error_event = 6'h00;
        cyc(5);
        hresetn <= 1'b1;
        cyc(int'(pmr_pkg::WAKE_PO_CYC));
        chk(32'(hresp), 32'h0);
        chk(32'(power_mode), STB);
        chk(32'(standby_status_bit), 32'h1);
        chk(32'(sense_mux_select), 32'h7);
        rd(8'h04, 32'h4, 32'h4);
        rd(8'h04, 32'h4, 32'h0);
        // Register wake: the output stays off until the wake time has run.
        wr(8'h00, 32'h0000_0100);
        cyc(100);
        chk(32'(power_outputs), 32'h0);
        chk(32'(power_mode), 32'(pmr_pkg::MODE_IDLE));
        cyc(2500);
        chk(32'(power_outputs), 32'h1);
        chk(32'(sense_enable), 32'h1);
        chk(32'(power_mode), 32'(pmr_pkg::MODE_NORMAL));
        // Mapping mode: pin 0 drives the masked channels at once since a channel is already on.
        wr(8'h00, 32'h0030_0108);
        pins(3'h1, 20);
        chk(32'(power_outputs), 32'h31);
        pins(3'h0, 10);
        ev(6'h01);
        cyc(3);
        chk(32'(power_outputs), 32'h0);
        rd(8'h04, 32'h3F00, 32'h0100);
        // Falling back to stand-by keeps the registers but clears the errors.
        wr(8'h00, 32'h0000_0107);
        cyc(10);
        chk(32'(power_mode), STB);
        chk(32'(standby_status_bit), 32'h1);
        rd(8'h04, 32'h3F00, 32'h0);
        rd(8'h00, 32'h3F07, 32'h0107);
        // Pin wake is delayed, a second pin is not once a channel is on.
        pins(3'h2, 900);
        chk(32'(power_outputs & 6'h02), 32'h0);
        cyc(200);
        chk(32'(power_outputs & 6'h02), 32'h2);
        pins(3'h3, 20);
        chk(32'(power_outputs & 6'h03), 32'h3);
        pins(3'h0, 10);
        chk(32'(power_mode), STB);
        // Reset command: register outputs drop, pin outputs stay.
        wr(8'h00, 32'h0000_0800);
        pins(3'h4, 2600);
        chk(32'(power_outputs), 32'h0C);
        wr(8'h00, 32'h0000_0810);
        cyc(5);
        chk(32'(power_outputs), 32'h04);
        cyc(60);
        rd(8'h04, 32'h4, 32'h4);
        rd(8'h00, 32'h3F3F, 32'h0007);
        ev(6'h04);
        cyc(3);
        chk(32'(power_outputs), 32'h0);
        rd(8'h04, 32'h3F00, 32'h0400);
        pins(3'h0, 10);
        rd(8'h04, 32'h3F00, 32'h0);
        // Without logic supply the pins still drive their channels; all pins low is stand-by.
        logic_supply_ok <= 1'b0;
        pins(3'h2, 1100);
        chk(32'(power_outputs), 32'h02);
        pins(3'h0, 10);
        chk(32'(power_mode), STB);
        logic_supply_ok <= 1'b1;
        cyc(int'(pmr_pkg::WAKE_PO_CYC));
        rd(8'h04, 32'h4, 32'h4);
        // Limp home: a short pulse must not count toward the acceptance time.
        limp_home_input <= 1'b1;
        cyc(600);
        limp_home_input <= 1'b0;
        cyc(20);
        limp_home_input <= 1'b1;
        cyc(1200);
        chk(32'(limp_active), 32'h0);
        cyc(100);
        chk(32'(limp_active), 32'h1);
        wr(8'h00, 32'h0000_0100);
        rd(8'h00, 32'h3F07, 32'h0007);
        rd(8'h04, 32'h2, 32'h2);
        chk(32'(power_mode), 32'(pmr_pkg::MODE_LIMP));
        // Without battery the limp hold lets go, so only the write block keeps the registers.
        battery_ok <= 1'b0;
        cyc(10);
        chk(32'(power_mode), 32'(pmr_pkg::MODE_OFF));
        wr(8'h00, 32'h0000_0100);
        rd(8'h00, 32'h3F07, 32'h0007);
        battery_ok <= 1'b1;
        cyc(10);
        chk(32'(sense_enable), 32'h0);
        pins(3'h1, 1100);
        chk(32'(power_outputs), 32'h01);
        ev(6'h01);
        cyc(3);
        chk(32'(power_outputs), 32'h0);
        pins(3'h0, 10);
        pins(3'h1, 1100);
        chk(32'(power_outputs), 32'h01);
        limp_home_input <= 1'b0;
        cyc(10);
        chk(32'(limp_active), 32'h0);
        report_and_stop();
    end
endmodule : testbench
